/* hw/input_check_regs.vh */
`ifndef INPUT_CHECK_REGS_VH
`define INPUT_CHECK_REGS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define ADDR_WIDTH               7
`define DATA_WIDTH               16
`define INPUT_CHECK_CONFIG_ADDR  7'h01
`define ALARM_STATUS_ADDR        7'h05
`define INPUT_CHECK_CONFIG_RESET 16'h050E

// ****************************************************************
// Field positions of input_check_config
// ****************************************************************
`define PATTERN_CHECK_ENABLE_BIT 15
`define GOOD_SAMPLE_AUTOCLEAR_ENABLE_BIT 12
`define PARITY_SENSE_BIT         11
`define WORD_PARITY_ENABLE_BIT   10
`define FRAME_PARITY_ENABLE_BIT  9
`define INPHASE_OUTPUT_INVERT_BIT 6
`define QUADRATURE_OUTPUT_INVERT_BIT 5
`define POINTER_TWO_APART_WARN_ENABLE_BIT 3
`define POINTER_ONE_APART_WARN_ENABLE_BIT 2
`define POINTER_COLLISION_WARN_ENABLE_BIT 1

// ****************************************************************
// Alarm status layout
// ****************************************************************
`define ALARM_WIDTH              5
`define ALARM_COLLISION_BIT      0
`define ALARM_ONE_APART_BIT      1
`define ALARM_TWO_APART_BIT      2
`define ALARM_PARITY_BIT         3
`define ALARM_PATTERN_BIT        4

// ****************************************************************
// Counts
// ****************************************************************
`define GOOD_SAMPLE_COUNT        7'd64
`define GOOD_COUNT_WIDTH         7

`endif

/* hw/input_check_config.v */
// Behaviour
// - Pattern-check enable runs the checker and forces outputs off regardless of enables.
// - Auto-clear enable clears alarms after 64 consecutive good samples.
// - Parity sense bit: zero selects even parity, one selects odd parity.
// - Word parity enable checks every input word against the parity input pair.
// - Frame parity enable checks parity using the frame input as parity bit.
// - Bit 6 complements the in-phase channel output.
// - Bit 5 complements the quadrature channel output.
// - Bit 3 enables the two-apart pointer alarm; otherwise it stays suppressed.
// - Bit 2 enables the one-apart pointer alarm; otherwise it stays suppressed.
// - Bit 1 enables the pointer collision alarm; otherwise it stays suppressed.
// - Register sits at offset one and resets to 0x050E.
`timescale 1ns/1ps
`include "input_check_regs.vh"

module input_check_config (
  input  wire                         clock,
  input  wire                         sys_rst,
  input  wire                         clock_enable,
  input  wire [`ADDR_WIDTH-1:0]       reg_addr,
  input  wire                         reg_write,
  input  wire                         reg_read,
  input  wire [`DATA_WIDTH-1:0]       reg_wdata,
  output reg  [`DATA_WIDTH-1:0]       reg_rdata,
  input  wire                         tx_enable_pin,
  input  wire                         sif_tx_enable,
  input  wire                         sample_valid,
  input  wire [`DATA_WIDTH-1:0]       inphase_sample,
  input  wire [`DATA_WIDTH-1:0]       quadrature_sample,
  input  wire                         check_bit_input_pair,
  input  wire                         frame_bit,
  input  wire                         pattern_mismatch,
  input  wire                         fifo_two_apart,
  input  wire                         fifo_one_apart,
  input  wire                         fifo_collision,
  output wire                         pattern_check_run,
  output reg                          outputs_active,
  output reg  [`DATA_WIDTH-1:0]       inphase_channel_output,
  output reg  [`DATA_WIDTH-1:0]       quadrature_channel_output,
  output reg                          parity_error,
  output reg  [`ALARM_WIDTH-1:0]      alarm_status
);

  // ****************************************************************
  // Parity check
  // ****************************************************************
  // True when the data bits plus the check bit carry the selected sense.
  function parity_ok;
    input [2*`DATA_WIDTH-1:0] data;
    input                     check_bit;
    input                     odd_sense;
    begin
      parity_ok = ((^data) ^ check_bit) == odd_sense;
    end
  endfunction

  // Complementing a word swaps the sense of each differential data pair.
  function [`DATA_WIDTH-1:0] apply_invert;
    input [`DATA_WIDTH-1:0] data;
    input                   invert;
    begin
      apply_invert = invert ? ~data : data;
    end
  endfunction

  reg  [`DATA_WIDTH-1:0]       config_reg;
  reg  [`DATA_WIDTH-1:0]       config_next;
  reg  [`ALARM_WIDTH-1:0]      alarm_next;
  reg  [`GOOD_COUNT_WIDTH-1:0] good_count_reg;
  reg  [`GOOD_COUNT_WIDTH-1:0] good_count_next;
  reg                          autoclear;
  reg  [`ALARM_WIDTH-1:0]      alarm_set;
  reg  [`ALARM_WIDTH-1:0]      alarm_clear;

  wire                   pattern_enable;
  wire                   odd_sense;
  wire                   word_parity_enable;
  wire                   frame_parity_enable;
  wire [2*`DATA_WIDTH-1:0] sample_pair;
  wire                   word_parity_bad;
  wire                   frame_parity_bad;
  wire                   parity_bad;
  wire                   pattern_bad;
  wire                   sample_good;
  wire                   config_hit;
  wire                   status_hit;

  assign pattern_enable      = config_reg[`PATTERN_CHECK_ENABLE_BIT];
  assign odd_sense           = config_reg[`PARITY_SENSE_BIT];
  assign word_parity_enable  = config_reg[`WORD_PARITY_ENABLE_BIT];
  assign frame_parity_enable = config_reg[`FRAME_PARITY_ENABLE_BIT];
  assign sample_pair         = {inphase_sample, quadrature_sample};
  assign config_hit          = reg_addr == `INPUT_CHECK_CONFIG_ADDR;
  assign status_hit          = reg_addr == `ALARM_STATUS_ADDR;

  // The source is trusted to send parity in the selected sense; any
  // mismatch is reported, never corrected.
  assign word_parity_bad  = word_parity_enable &
                            ~parity_ok(sample_pair, check_bit_input_pair, odd_sense);
  assign frame_parity_bad = frame_parity_enable &
                            ~parity_ok(sample_pair, frame_bit, odd_sense);
  assign parity_bad       = word_parity_bad | frame_parity_bad;
  assign pattern_bad      = pattern_enable & pattern_mismatch;
  assign sample_good      = ~parity_bad & ~pattern_bad;

  // The test flag follows the stored bit directly, so the external
  // checker starts in the cycle after the write.
  assign pattern_check_run = pattern_enable;

  // ****************************************************************
  // Alarm set, clear and good-sample run
  // ****************************************************************
  always @* begin
    // Each pointer event is gated by its enable before it can reach the
    // sticky status, so a suppressed alarm leaves no trace.
    alarm_set = {`ALARM_WIDTH{1'b0}};
    alarm_set[`ALARM_TWO_APART_BIT] = fifo_two_apart &
      config_reg[`POINTER_TWO_APART_WARN_ENABLE_BIT];
    alarm_set[`ALARM_ONE_APART_BIT] = fifo_one_apart &
      config_reg[`POINTER_ONE_APART_WARN_ENABLE_BIT];
    alarm_set[`ALARM_COLLISION_BIT] = fifo_collision &
      config_reg[`POINTER_COLLISION_WARN_ENABLE_BIT];
    alarm_set[`ALARM_PARITY_BIT]  = sample_valid & parity_bad;
    alarm_set[`ALARM_PATTERN_BIT] = sample_valid & pattern_bad;

    // The run is counted whether or not auto-clear is on, and any bad
    // sample, parity or pattern, starts it again from zero.
    good_count_next = good_count_reg;
    autoclear       = 1'b0;
    if (sample_valid) begin
      if (!sample_good) begin
        good_count_next = {`GOOD_COUNT_WIDTH{1'b0}};
      end else if (good_count_reg == `GOOD_SAMPLE_COUNT - 7'd1) begin
        good_count_next = {`GOOD_COUNT_WIDTH{1'b0}};
        autoclear = config_reg[`GOOD_SAMPLE_AUTOCLEAR_ENABLE_BIT];
      end else begin
        good_count_next = good_count_reg + 7'd1;
      end
    end

    alarm_clear = {`ALARM_WIDTH{1'b0}};
    if (autoclear) begin
      alarm_clear = {`ALARM_WIDTH{1'b1}};
    end
    if (reg_write && status_hit) begin
      alarm_clear = alarm_clear | reg_wdata[`ALARM_WIDTH-1:0];
    end
    // A new event in the clearing cycle survives the clear.
    alarm_next = (alarm_status & ~alarm_clear) | alarm_set;
  end

  // ****************************************************************
  // Configuration write
  // ****************************************************************
  // All sixteen bits are stored, reserved ones included, so software
  // reads back exactly what it wrote; reserved bits steer nothing.
  always @* begin
    config_next = config_reg;
    if (reg_write && config_hit) begin
      config_next = reg_wdata;
    end
  end

  // ****************************************************************
  // Register state
  // ****************************************************************
  // Reset acts even while the clock enable is low, so a frozen block can
  // always be brought back to its defaults.
  always @(posedge clock) begin
    if (sys_rst) begin
      config_reg     <= `INPUT_CHECK_CONFIG_RESET;
      alarm_status   <= {`ALARM_WIDTH{1'b0}};
      good_count_reg <= {`GOOD_COUNT_WIDTH{1'b0}};
    end else if (clock_enable) begin
      config_reg     <= config_next;
      alarm_status   <= alarm_next;
      good_count_reg <= good_count_next;
    end
  end

  // ****************************************************************
  // Read-back
  // ****************************************************************
  // Read data is held between reads so the host may take it late.
  always @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= {`DATA_WIDTH{1'b0}};
    end else if (clock_enable && reg_read) begin
      if (config_hit) begin
        reg_rdata <= config_reg;
      end else if (status_hit) begin
        reg_rdata <= {{(`DATA_WIDTH-`ALARM_WIDTH){1'b0}}, alarm_status};
      end else begin
        reg_rdata <= {`DATA_WIDTH{1'b0}};
      end
    end
  end

  // ****************************************************************
  // Transmit gate and channel outputs
  // ****************************************************************
  // The gate is registered, so outputs switch off one cycle after the
  // pattern test is enabled; a glitch-free gate was preferred to speed.
  always @(posedge clock) begin
    if (sys_rst) begin
      outputs_active            <= 1'b0;
      parity_error              <= 1'b0;
      inphase_channel_output    <= {`DATA_WIDTH{1'b0}};
      quadrature_channel_output <= {`DATA_WIDTH{1'b0}};
    end else if (clock_enable) begin
      outputs_active <= tx_enable_pin & sif_tx_enable & ~pattern_enable;
      parity_error   <= sample_valid & parity_bad;
      if (sample_valid) begin
        inphase_channel_output    <= apply_invert(inphase_sample,
                                       config_reg[`INPHASE_OUTPUT_INVERT_BIT]);
        quadrature_channel_output <= apply_invert(quadrature_sample,
                                       config_reg[`QUADRATURE_OUTPUT_INVERT_BIT]);
      end
    end
  end

endmodule

/* sim/input_check_config_assertions.sv */
`timescale 1ns/1ps
`include "input_check_regs.vh"
module input_check_config_assertions (
  input wire logic                     clock,
  input wire logic                     sys_rst,
  input wire logic                     clock_enable,
  input wire logic [`ADDR_WIDTH-1:0]   reg_addr,
  input wire logic                     reg_write,
  input wire logic [`DATA_WIDTH-1:0]   reg_wdata,
  input wire logic                     sample_valid,
  input wire logic [`DATA_WIDTH-1:0]   inphase_sample,
  input wire logic [`DATA_WIDTH-1:0]   quadrature_sample,
  input wire logic                     pattern_mismatch,
  input wire logic                     fifo_collision,
  input wire logic                     pattern_check_run,
  input wire logic                     outputs_active,
  input wire logic [`DATA_WIDTH-1:0]   inphase_channel_output,
  input wire logic [`DATA_WIDTH-1:0]   quadrature_channel_output,
  input wire logic                     parity_error,
  input wire logic [`ALARM_WIDTH-1:0]  alarm_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [`DATA_WIDTH-1:0] config_model_reg;
  // Mirror of the stored configuration, rebuilt from the writes the block takes.
  always @(posedge clock) begin
    if (sys_rst) begin
      config_model_reg <= `INPUT_CHECK_CONFIG_RESET;
    end else if (clock_enable && reg_write && reg_addr == `INPUT_CHECK_CONFIG_ADDR) begin
      config_model_reg <= reg_wdata;
    end
  end
  AST_RUN_FOLLOWS_WRITE: assert property (clock_enable && reg_write && reg_addr == 7'h01
    |=> pattern_check_run == $past(reg_wdata[15])) else $error("run flag not loaded");
  AST_OUTPUTS_OFF: assert property (clock_enable && pattern_check_run |=> !outputs_active)
    else $error("outputs active during pattern test");
  AST_PATTERN_CAUSE: assert property ($rose(alarm_status[4]) |->
    $past(pattern_mismatch && sample_valid && pattern_check_run)) else $error("pattern alarm");
  AST_PARITY_CAUSE: assert property ($past(clock_enable) && parity_error |-> $past(sample_valid))
    else $error("parity error without sample");
  AST_PARITY_STICKY: assert property (parity_error |-> alarm_status[3])
    else $error("parity alarm not set");
  AST_INPHASE_OUT: assert property ($past(sample_valid && clock_enable) && !$past(sys_rst) |->
    inphase_channel_output == ($past(config_model_reg[`INPHASE_OUTPUT_INVERT_BIT]) ?
    ~$past(inphase_sample) : $past(inphase_sample))) else $error("in-phase output wrong");
  AST_QUAD_OUT: assert property ($past(sample_valid && clock_enable) && !$past(sys_rst) |->
    quadrature_channel_output == ($past(config_model_reg[`QUADRATURE_OUTPUT_INVERT_BIT]) ?
    ~$past(quadrature_sample) : $past(quadrature_sample))) else $error("quadrature output wrong");
  AST_QUAD_HOLD: assert property (!$past(sample_valid) && !$past(sys_rst)
    |-> $stable(quadrature_channel_output)) else $error("quadrature output moved");
  AST_COLLISION_CAUSE: assert property ($rose(alarm_status[0]) |-> $past(fifo_collision))
    else $error("collision alarm without event");
  cover property (parity_error);
  cover property ($rose(alarm_status[4]));
  cover property (outputs_active);
endmodule

bind input_check_config input_check_config_assertions u_chk (.clock(clock), .sys_rst(sys_rst),
  .clock_enable(clock_enable), .reg_addr(reg_addr), .reg_write(reg_write),
  .reg_wdata(reg_wdata), .sample_valid(sample_valid), .inphase_sample(inphase_sample),
  .quadrature_sample(quadrature_sample),
  .pattern_mismatch(pattern_mismatch), .fifo_collision(fifo_collision),
  .pattern_check_run(pattern_check_run), .outputs_active(outputs_active),
  .inphase_channel_output(inphase_channel_output), .parity_error(parity_error),
  .quadrature_channel_output(quadrature_channel_output), .alarm_status(alarm_status));

/* sim/host_source.sv */
`timescale 1ns/1ps
module host_source (
  input  wire logic [31:0] data,
  input  wire logic        odd_sense,
  input  wire logic        corrupt,
  output logic             check_bit
);
  // Corrupt is raised by scenarios that expect a parity error and by ones where its parity check is disabled.
  assign check_bit = ^data ^ odd_sense ^ corrupt;
endmodule

/* sim/input_check_config_tb.sv */
`timescale 1ns/1ps
`include "input_check_regs.vh"
module input_check_config_tb;
  logic clock = 0, sys_rst = 1, wr = 0, rd = 0, sv = 0, pm = 0, f2 = 0, f1 = 0, fc = 0;
  logic bad = 0, odd = 0, pchk, run, act, perr;
  logic ce = 1, txp = 1, stx = 1, badf = 0, fbit;
  logic [6:0]  addr = 7'h00;
  logic [15:0] wd = 16'h0000, si = 16'h0000, sq = 16'h0000, rdat, oi, oq;
  logic [4:0]  al;
  int          num_errors = 0, cmp_count = 0, cyc = 0;
  always #12.5 clock = ~clock;
  input_check_config u_dut (.clock(clock), .sys_rst(sys_rst), .clock_enable(ce),
    .reg_addr(addr), .reg_write(wr), .reg_read(rd), .reg_wdata(wd), .reg_rdata(rdat),
    .tx_enable_pin(txp), .sif_tx_enable(stx), .sample_valid(sv), .inphase_sample(si),
    .quadrature_sample(sq), .check_bit_input_pair(pchk), .frame_bit(fbit),
    .pattern_mismatch(pm), .fifo_two_apart(f2), .fifo_one_apart(f1), .fifo_collision(fc),
    .pattern_check_run(run), .outputs_active(act), .inphase_channel_output(oi),
    .quadrature_channel_output(oq), .parity_error(perr), .alarm_status(al));
  host_source u_src (.data({si, sq}), .odd_sense(odd), .corrupt(bad), .check_bit(pchk));
  host_source u_frm (.data({si, sq}), .odd_sense(odd), .corrupt(badf), .check_bit(fbit));
  task complete_run;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wreg(input logic [6:0] a, input logic [15:0] d);
    @(negedge clock); addr = a; wd = d; wr = 1;
    @(negedge clock); wr = 0;
  endtask
  task rreg(input logic [6:0] a, input logic [15:0] e);
    @(negedge clock); addr = a; rd = 1;
    @(negedge clock); rd = 0; chk(rdat, e);
  endtask
  task smp(input logic [15:0] i, input logic [15:0] q, input logic b, input logic p,
           input logic e);
    @(negedge clock); si = i; sq = q; bad = b; pm = p; sv = 1;
    @(negedge clock); sv = 0; chk({15'h0000, perr}, {15'h0000, e});
  endtask
  always @(posedge clock) begin
    cyc++;
    // A hang is cut off well beyond the few hundred cycles the sequence needs.
    if (cyc == 3000) begin num_errors++; complete_run; end
  end
  initial begin
    repeat (6) @(negedge clock);
    sys_rst = 0;
    rreg(7'h01, 16'h050E);
    rreg(7'h7F, 16'h0000);
    wreg(7'h01, 16'h0000);
    for (int k = 1; k < 4; k++) begin
      @(negedge clock); f2 = 1; f1 = 1; fc = 1;
      @(negedge clock); f2 = 0; f1 = 0; fc = 0;
      rreg(7'h05, 16'h0000);
      wreg(7'h01, 16'h0001 << k);
      @(negedge clock); f2 = 1; f1 = 1; fc = 1;
      @(negedge clock); f2 = 0; f1 = 0; fc = 0;
      rreg(7'h05, 16'h0001 << (k - 1));
      wreg(7'h05, 16'h001F);
      wreg(7'h01, 16'h0000);
    end
    for (int s = 0; s < 2; s++) begin
      odd = s[0];
      badf = 1;
      wreg(7'h01, 16'h0400 | (16'(s) << 11));
      smp(16'h0001, 16'h0000, 0, 0, 0);
      smp(16'h0001, 16'h0000, 1, 0, 1);
    end
    odd = 0;
    wreg(7'h01, 16'h0200);
    badf = 1;
    smp(16'h0003, 16'h8000, 0, 0, 1);
    badf = 0;
    smp(16'h0003, 16'h8000, 1, 0, 0);
    wreg(7'h01, 16'h0000);
    badf = 1;
    smp(16'h0003, 16'h8000, 1, 0, 0);
    badf = 0;
    rreg(7'h05, 16'h0008);
    wreg(7'h05, 16'h001F);
    wreg(7'h01, 16'h0060);
    smp(16'h1234, 16'hA5C3, 0, 0, 0);
    chk(oi, 16'hEDCB);
    chk(oq, 16'h5A3C);
    wreg(7'h01, 16'h0020);
    smp(16'h1234, 16'hA5C3, 0, 0, 0);
    chk(oi, 16'h1234);
    chk(oq, 16'h5A3C);
    chk({15'h0000, act}, 16'h0001);
    txp = 0;
    @(negedge clock);
    chk({15'h0000, act}, 16'h0000);
    txp = 1;
    stx = 0;
    @(negedge clock);
    chk({15'h0000, act}, 16'h0000);
    stx = 1;
    wreg(7'h01, 16'h8000);
    smp(16'h0000, 16'h0000, 0, 1, 0);
    chk({14'h0000, run, act}, 16'h0002);
    rreg(7'h05, 16'h0010);
    wreg(7'h01, 16'h1400);
    smp(16'h0000, 16'h0000, 1, 0, 1);
    repeat (63) smp(16'h0000, 16'h0000, 0, 0, 0);
    rreg(7'h05, 16'h0018);
    smp(16'h0000, 16'h0000, 0, 0, 0);
    rreg(7'h05, 16'h0000);
    smp(16'h0000, 16'h0000, 1, 0, 1);
    @(negedge clock);
    sys_rst = 1;
    @(negedge clock);
    sys_rst = 0;
    rreg(7'h01, 16'h050E);
    rreg(7'h05, 16'h0000);
    ce = 0;
    wreg(7'h01, 16'h8000);
    ce = 1;
    rreg(7'h01, 16'h050E);
    chk({15'h0000, run}, 16'h0000);
    complete_run;
  end
endmodule
